// >>> ams_partner_model.sv
// ams_partner_model: shared converter and three remote isolated sensors.
// assumes the sequencer's clock; a result comes 20 cycles after each start.
`timescale 1ns/1ns
module ams_partner_model
  import ams_pkg::*;
(
  input wire logic clock_i, // system clock
  input wire logic start_i, // conversion start
  input wire ams_sel_t sel_i, // multiplexer selection
  output logic done_o, // result pulse
  output logic [DATA_W-1:0] data_o, // result
  input wire logic [REMOTE_PAIRS-1:0] link_en_i, // pairs as links
  output logic [REMOTE_PAIRS-1:0] valid_o, // remote sample offered
  output logic [REMOTE_PAIRS-1:0][DATA_W-1:0] rdata_o, // remote samples
  input wire logic [REMOTE_PAIRS-1:0] ready_i // remote sample taken
);
  int cnt = 0;
  logic [3:0] ch = 4'h0;
  initial begin
    done_o = 1'b0;
    data_o = '0;
    valid_o = '0;
    rdata_o = '0;
  end
  // idle data lines toggle every cycle so a stale value can never pass
  always @(posedge clock_i) begin
    done_o <= 1'b0;
    data_o <= ~data_o;
    if (cnt > 0) cnt <= cnt - 1;
    if (start_i) begin
      cnt <= 20;
      ch <= sel_i.chan;
    end
    if (cnt == 1) begin
      done_o <= 1'b1;
      data_o <= {18'h1_2345, ch};
    end
    // one remote sample per pair per frame, offered when a frame starts on CH_I0
    for (int k = 0; k < REMOTE_PAIRS; k++) begin
      if (start_i && sel_i.chan == CH_I0 && link_en_i[k]) begin
        valid_o[k] <= 1'b1;
        rdata_o[k] <= {18'h2_6789, 4'(k)};
      end else if (valid_o[k] && ready_i[k]) begin
        valid_o[k] <= 1'b0;
        rdata_o[k] <= ~rdata_o[k];
      end else if (!valid_o[k]) begin
        rdata_o[k] <= ~rdata_o[k];
      end
    end
  end
endmodule : ams_partner_model

// >>> ams_pkg.sv
// ams_pkg: constants and types for the converter input sequencer.
// assumes a single 20 MHz system clock and a 32768 Hz low-speed clock pin.
package ams_pkg;

  localparam int unsigned CLOCK_HZ = 20_000_000;
  localparam int unsigned LOW_SPEED_HZ = 32_768;

  // register offsets (byte addresses on the plain register port)
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;

  // control field layout
  localparam int unsigned CTRL_W = 12;
  localparam int unsigned CTRL_COUNT_LSB = 0;
  localparam int unsigned CTRL_DIFF0_BIT = 4;
  localparam int unsigned CTRL_DIFF123_LSB = 5;
  localparam int unsigned CTRL_PREAMP_BIT = 8;
  localparam int unsigned CTRL_REMOTE_BIT = 9;
  localparam int unsigned CTRL_RUN_BIT = 10;
  localparam int unsigned CTRL_ODD_BIT = 11;

  // sequencing
  localparam int unsigned MAX_STATES = 7;
  localparam logic [3:0] STATE_FIRST = 4'h1;
  localparam logic [3:0] COUNT_RESET = 4'h7;
  localparam logic [1:0] CONV_TICKS = 2'h2;
  localparam int unsigned FRAME_TICKS_REMOTE = 13;
  localparam int unsigned FRAME_TICKS_LOCAL = 15;
  localparam int unsigned REMOTE_PAIRS = 3;
  localparam int unsigned BUF_DEPTH = 2;

  // input channel numbers: current pins 0..7, voltage pins 8..10
  localparam logic [3:0] CH_I0 = 4'h0;
  localparam logic [3:0] CH_I1 = 4'h1;
  localparam logic [3:0] CH_I2 = 4'h2;
  localparam logic [3:0] CH_I4 = 4'h4;
  localparam logic [3:0] CH_I6 = 4'h6;
  localparam logic [3:0] CH_V8 = 4'h8;
  localparam logic [3:0] CH_V9 = 4'h9;
  localparam logic [3:0] CH_V10 = 4'hA;
  localparam logic [7:0] RAM_BASE = 8'h00;

  localparam int unsigned DATA_W = 22;

  typedef struct packed {
    logic odd_pin;
    logic run;
    logic remote_sensor_enable;
    logic preamp_enable;
    logic [2:0] pair_differential_enable;
    logic first_pair_differential_enable;
    logic [3:0] frame_state_count;
  } ams_ctrl_t;

  localparam ams_ctrl_t CTRL_RESET = '{odd_pin: 1'b0, run: 1'b0, remote_sensor_enable: 1'b0,
    preamp_enable: 1'b0, pair_differential_enable: 3'h0,
    first_pair_differential_enable: 1'b0, frame_state_count: COUNT_RESET};

  typedef struct packed {
    logic valid;
    logic [3:0] chan;
    logic diff;
    logic preamp;
  } ams_sel_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [DATA_W-1:0] data;
  } ams_ram_wr_t;

  typedef enum logic [2:0] {
    SQ_IDLE = 3'b001,
    SQ_CONV = 3'b010,
    SQ_HOLD = 3'b100
  } ams_fsm_t;

endpackage : ams_pkg

// >>> ams_sequencer.sv
// ams_sequencer: steps the shared converter through the enabled inputs once per
// frame, timed by the low-speed clock, and queues results for compute-engine RAM.
// assumes converter, remote decimators and RAM port run on clock_i.
//
// The register addresses and the address-and-strobe port were decided locally.
`timescale 1ns/1ns

// Operation
// - enabled inputs converted one at a time
// - at most seven selections per frame
// - frame starts state 1, runs count states
// - remote mode frame is 13 ticks
// - remote frame holds two unused slots
// - remote samples second half, no slot
// - local mode frame is 15 ticks
// - preamp bit routes first pair gain-8
// - first two pins individually single/differential
// - first pair differential enable bit
// - remote bit makes pairs 2-4 links
// - remote bit clear: pairs 2-4 analog
// - first pair never a remote link
// - remote pairs bypass the multiplexer
// - current pins single-ended or paired
// - result written to selection's RAM location; code clears channel bit 0, so pin 9 writes pin 8's word
module ams_sequencer
  import ams_pkg::*;
(
  input wire logic clock_i, // 20 MHz system clock
  input wire logic rst_i, // async reset, active high
  input wire logic low_speed_clock_i, // 32768 Hz pin, asynchronous
  input wire logic [7:0] reg_addr_i, // register byte address
  input wire logic [31:0] reg_wdata_i, // register write data
  input wire logic reg_wr_i, // write strobe
  input wire logic reg_rd_i, // read strobe
  output logic [31:0] reg_rdata_o, // read data, cycle after strobe
  output logic conv_start_o, // one-cycle conversion start
  output ams_sel_t conv_sel_o, // multiplexer selection
  input wire logic conv_done_i, // filtered result ready
  input wire logic [DATA_W-1:0] conv_data_i, // filtered result
  output logic conv_ready_o, // result accepted when high
  output logic [REMOTE_PAIRS-1:0] rmt_link_en_o, // pairs 2-4 as digital links
  input wire logic [REMOTE_PAIRS-1:0] rmt_valid_i, // remote sample offered
  input wire logic [REMOTE_PAIRS-1:0][DATA_W-1:0] rmt_data_i, // remote samples
  output logic [REMOTE_PAIRS-1:0] rmt_ready_o, // remote sample taken
  output logic ram_wr_valid_o, // RAM write pending
  output ams_ram_wr_t ram_wr_o, // RAM write address and data
  input wire logic ram_wr_ready_i // RAM takes the write
);

  typedef struct packed {
    logic [2:0] sync;
    ams_ctrl_t ctrl;
    ams_fsm_t fsm;
    logic [4:0] ftick;
    logic [3:0] slot;
    logic [1:0] phase;
    logic [7:0] frames;
    logic start;
    ams_sel_t sel;
    logic [31:0] rdata;
    ams_ram_wr_t [BUF_DEPTH-1:0] ent;
    logic wr_ptr;
    logic rd_ptr;
    logic [1:0] cnt;
  } ams_state_t;

  ams_state_t s;
  ams_state_t next_s;

  // count of zero would give an empty frame; run one state instead
  function automatic logic [3:0] eff_count(input ams_ctrl_t c);
    eff_count = (c.frame_state_count == 4'h0) ? STATE_FIRST : c.frame_state_count;
  endfunction : eff_count

  // frame length in low-speed ticks: two per state plus one
  function automatic logic [4:0] last_tick(input ams_ctrl_t c);
    last_tick = {eff_count(c), 1'b0};
  endfunction : last_tick

  // selection for a given state; in remote mode pairs 2-4 never appear
  function automatic ams_sel_t pick(input logic [3:0] st, input ams_ctrl_t c);
    ams_sel_t r;
    logic [3:0] ch;
    r = '0;
    ch = CH_I0;
    if (c.remote_sensor_enable) begin
      case (st)
        4'h1: ch = CH_I0;
        4'h2: ch = CH_V8;
        4'h3: ch = CH_V9;
        4'h4: ch = CH_V10;
        default: ch = 4'hF;
      endcase
    end else begin
      case (st)
        4'h1: ch = CH_I0;
        4'h2: ch = CH_V8;
        4'h3: ch = CH_I2;
        4'h4: ch = CH_V9;
        4'h5: ch = CH_I4;
        4'h6: ch = CH_V10;
        4'h7: ch = CH_I6;
        default: ch = 4'hF;
      endcase
    end
    r.valid = (ch != 4'hF);
    r.chan = ch;
    if (ch == CH_I0) begin
      r.diff = c.first_pair_differential_enable;
      r.preamp = c.preamp_enable;
      if (!c.first_pair_differential_enable && c.odd_pin) begin
        r.chan = CH_I1;
      end
    end else if (ch < CH_V8) begin
      r.diff = c.pair_differential_enable[ch[2:1] - 2'd1];
    end
    pick = r;
  endfunction : pick

  logic tick;
  logic second_half;
  logic [REMOTE_PAIRS-1:0] grant;
  logic push;
  ams_ram_wr_t push_word;

  // first sync stage is only read by the second
  assign tick = s.sync[1] & ~s.sync[2];
  assign second_half = (s.fsm != SQ_IDLE) && (s.ftick > {1'b0, eff_count(s.ctrl)});

  // remote samples bypass the converter; the converter result wins a busy cycle
  always_comb begin
    grant = '0;
    if (s.ctrl.remote_sensor_enable && second_half && !conv_done_i && s.cnt < 2'(BUF_DEPTH)) begin
      if (rmt_valid_i[0]) begin
        grant = 3'b001;
      end else if (rmt_valid_i[1]) begin
        grant = 3'b010;
      end else if (rmt_valid_i[2]) begin
        grant = 3'b100;
      end
    end
  end

  always_comb begin
    push_word = '0;
    push = 1'b0;
    if (conv_done_i && s.cnt < 2'(BUF_DEPTH)) begin
      push = 1'b1;
      push_word.addr = RAM_BASE + {4'h0, s.sel.chan & 4'hE};
      push_word.data = conv_data_i;
    end else begin
      for (int k = 0; k < REMOTE_PAIRS; k++) begin
        if (grant[k]) begin
          push = 1'b1;
          push_word.addr = RAM_BASE + 8'(2 * (k + 1));
          push_word.data = rmt_data_i[k];
        end
      end
    end
  end

  always_comb begin
    logic pop;
    pop = (s.cnt != 2'h0) && ram_wr_ready_i;
    next_s = s;
    next_s.sync = {s.sync[1:0], low_speed_clock_i};
    next_s.start = 1'b0;
    next_s.rdata = '0;

    if (reg_wr_i) begin
      if (reg_addr_i == CTRL_OFS) begin
        next_s.ctrl = reg_wdata_i[CTRL_W-1:0];
      end
    end
    if (reg_rd_i) begin
      if (reg_addr_i == CTRL_OFS) begin
        next_s.rdata = {20'h0_0000, s.ctrl};
      end else if (reg_addr_i == STATUS_OFS) begin
        next_s.rdata = {8'h00, s.frames, 3'h0, s.ftick, s.fsm == SQ_IDLE ? 1'b0 : 1'b1,
          3'h0, s.slot};
      end
    end

    if (tick) begin
      case (s.fsm)
        SQ_IDLE: begin
          if (s.ctrl.run) begin
            next_s.fsm = SQ_CONV;
            next_s.ftick = '0;
            next_s.slot = STATE_FIRST;
            next_s.phase = '0;
            next_s.sel = pick(STATE_FIRST, s.ctrl);
            next_s.start = next_s.sel.valid;
          end
        end
        SQ_CONV, SQ_HOLD: begin
          if (!s.ctrl.run) begin
            next_s.fsm = SQ_IDLE;
            next_s.slot = '0;
            next_s.ftick = '0;
          end else if (s.ftick >= last_tick(s.ctrl)) begin
            next_s.fsm = SQ_CONV;
            next_s.ftick = '0;
            next_s.slot = STATE_FIRST;
            next_s.phase = '0;
            next_s.frames = s.frames + 8'h01;
            next_s.sel = pick(STATE_FIRST, s.ctrl);
            next_s.start = next_s.sel.valid;
          end else begin
            next_s.ftick = s.ftick + 5'h01;
            if (s.fsm == SQ_CONV) begin
              if (s.phase == CONV_TICKS - 2'h1) begin
                next_s.phase = '0;
                if (s.slot >= eff_count(s.ctrl) || s.slot >= 4'(MAX_STATES)) begin
                  next_s.fsm = SQ_HOLD;
                  next_s.slot = '0;
                end else begin
                  next_s.slot = s.slot + 4'h1;
                  next_s.sel = pick(s.slot + 4'h1, s.ctrl);
                  next_s.start = next_s.sel.valid;
                end
              end else begin
                next_s.phase = s.phase + 2'h1;
              end
            end
          end
        end
        default: next_s.fsm = SQ_IDLE;
      endcase
    end

    if (push) begin
      next_s.ent[s.wr_ptr] = push_word;
      next_s.wr_ptr = ~s.wr_ptr;
    end
    if (pop) begin
      next_s.rd_ptr = ~s.rd_ptr;
    end
    next_s.cnt = s.cnt + 2'(push) - 2'(pop);
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      s <= '{sync: 3'h0, ctrl: CTRL_RESET, fsm: SQ_IDLE, ftick: 5'h00, slot: 4'h0,
        phase: 2'h0, frames: 8'h00, start: 1'b0, sel: '0, rdata: 32'h0000_0000,
        ent: '0, wr_ptr: 1'b0, rd_ptr: 1'b0, cnt: 2'h0};
    end else begin
      s <= next_s;
    end
  end

  assign reg_rdata_o = s.rdata;
  assign conv_start_o = s.start;
  assign conv_sel_o = s.sel;
  assign conv_ready_o = (s.cnt < 2'(BUF_DEPTH));
  assign rmt_ready_o = grant;
  assign rmt_link_en_o = {REMOTE_PAIRS{s.ctrl.remote_sensor_enable}};
  assign ram_wr_valid_o = (s.cnt != 2'h0);
  assign ram_wr_o = s.ent[s.rd_ptr];

  sequence s_frame_end;
    tick && s.fsm != SQ_IDLE && s.ctrl.run && s.ftick >= last_tick(s.ctrl);
  endsequence

  sequence s_frame_restart;
    s.slot == STATE_FIRST && s.ftick == 5'h00;
  endsequence

  property p_frame_start;
    @(posedge clock_i) disable iff (rst_i) s_frame_end |=> s_frame_restart;
  endproperty
  a_frame_start: assert property (p_frame_start) else $error("frame did not restart");

  property p_state_bound;
    @(posedge clock_i) disable iff (rst_i) s.slot <= 4'(MAX_STATES);
  endproperty
  a_state_bound: assert property (p_state_bound) else $error("state past seven");

  property p_frame_len;
    @(posedge clock_i) disable iff (rst_i)
      s.fsm != SQ_IDLE && $stable(s.ctrl) |-> s.ftick <= last_tick(s.ctrl);
  endproperty
  a_frame_len: assert property (p_frame_len) else $error("frame too long");

  property p_remote_bypass;
    @(posedge clock_i) disable iff (rst_i)
      conv_start_o && s.ctrl.remote_sensor_enable |->
        conv_sel_o.chan == CH_I0 || conv_sel_o.chan == CH_I1 || conv_sel_o.chan >= CH_V8;
  endproperty
  a_remote_bypass: assert property (p_remote_bypass) else $error("remote pair muxed");

  property p_preamp;
    @(posedge clock_i) disable iff (rst_i)
      conv_start_o && conv_sel_o.chan < CH_I2 |->
        conv_sel_o.preamp == s.ctrl.preamp_enable
        && conv_sel_o.diff == s.ctrl.first_pair_differential_enable;
  endproperty
  a_preamp: assert property (p_preamp) else $error("first pair setup wrong");

  property p_remote_half;
    @(posedge clock_i) disable iff (rst_i)
      |rmt_ready_o |-> s.ftick > {1'b0, eff_count(s.ctrl)} && s.ctrl.remote_sensor_enable;
  endproperty
  a_remote_half: assert property (p_remote_half) else $error("remote taken early");

  property p_unused_silent;
    @(posedge clock_i) disable iff (rst_i)
      s.fsm == SQ_HOLD || (s.ctrl.remote_sensor_enable && s.slot > 4'h4) |-> !conv_start_o;
  endproperty
  a_unused_silent: assert property (p_unused_silent) else $error("unused slot converted");

  property p_result_addr;
    @(posedge clock_i) disable iff (rst_i)
      conv_done_i && conv_ready_o && s.cnt == 2'h0 |=>
        ram_wr_valid_o && ram_wr_o.addr == RAM_BASE + {4'h0, $past(s.sel.chan) & 4'hE};
  endproperty
  a_result_addr: assert property (p_result_addr) else $error("result address wrong");

  // the checks below guard the start pulse, the remote grant, the buffer depth and the hold wait
  property p_start_pulse;
    @(posedge clock_i) disable iff (rst_i) conv_start_o |=> !conv_start_o;
  endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start longer than a cycle");

  property p_grant_onehot;
    @(posedge clock_i) disable iff (rst_i) $onehot0(rmt_ready_o);
  endproperty
  a_grant_onehot: assert property (p_grant_onehot) else $error("two remote grants");

  property p_local_no_grant;
    @(posedge clock_i) disable iff (rst_i) !s.ctrl.remote_sensor_enable |-> rmt_ready_o == '0;
  endproperty
  a_local_no_grant: assert property (p_local_no_grant) else $error("grant in local mode");

  // a full buffer drops the result rather than overwrite an unread entry
  property p_buf_bound;
    @(posedge clock_i) disable iff (rst_i)
      s.cnt <= 2'(BUF_DEPTH);
  endproperty
  a_buf_bound: assert property (p_buf_bound) else $error("buffer overfilled");

  property p_hold_wait;
    @(posedge clock_i) disable iff (rst_i)
      s.fsm == SQ_HOLD && s.ctrl.run && !(tick && s.ftick >= last_tick(s.ctrl)) |=>
        s.fsm == SQ_HOLD;
  endproperty
  a_hold_wait: assert property (p_hold_wait) else $error("hold left before frame end");

endmodule : ams_sequencer

// >>> tb.sv
// tb: self-checking bench for the converter input sequencer.
// assumes ams_sequencer and ams_partner_model; low-speed clock at 32768 Hz.
`timescale 1ns/1ns
module tb;
  import ams_pkg::*;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic low_speed_clock = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic rdy = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic [31:0] rdata;
  logic conv_start, conv_done, conv_ready, ram_wr_valid;
  ams_sel_t conv_sel;
  logic [DATA_W-1:0] conv_data;
  logic [REMOTE_PAIRS-1:0] link_en, rmt_valid, rmt_ready;
  logic [REMOTE_PAIRS-1:0][DATA_W-1:0] rmt_data;
  ams_ram_wr_t ram_wr;
  int err_total = 0;
  int cmp_count = 0;
  int ticks = 0;
  int cyc = 0;
  ams_sel_t sq[$];
  int st[$];
  int wt[$];
  ams_ram_wr_t wq[$];

  ams_sequencer dut (.clock_i(clock_i), .rst_i(rst_i), .low_speed_clock_i(low_speed_clock),
    .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
    .reg_rdata_o(rdata), .conv_start_o(conv_start), .conv_sel_o(conv_sel),
    .conv_done_i(conv_done), .conv_data_i(conv_data), .conv_ready_o(conv_ready),
    .rmt_link_en_o(link_en), .rmt_valid_i(rmt_valid), .rmt_data_i(rmt_data),
    .rmt_ready_o(rmt_ready), .ram_wr_valid_o(ram_wr_valid), .ram_wr_o(ram_wr),
    .ram_wr_ready_i(rdy));
  ams_partner_model pm (.clock_i(clock_i), .start_i(conv_start), .sel_i(conv_sel),
    .done_o(conv_done), .data_o(conv_data), .link_en_i(link_en), .valid_o(rmt_valid),
    .rdata_o(rmt_data), .ready_i(rmt_ready));

  always #25 clock_i = ~clock_i;
  initial begin
    #7;
    forever #15259 low_speed_clock = ~low_speed_clock;
  end
  always @(posedge low_speed_clock) ticks <= ticks + 1;
  always @(posedge clock_i) begin
    if (conv_start) begin
      sq.push_back(conv_sel);
      st.push_back(ticks);
    end
    if (ram_wr_valid && rdy) begin
      wq.push_back(ram_wr);
      wt.push_back(ticks);
    end
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      err_total++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    if (err_total == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock_i);
    reg_wr <= 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock_i);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock_i);
    reg_rd <= 1'b0;
    @(posedge clock_i);
    d = rdata;
  endtask : reg_read

  // runs until n frames have started, then clears run and lets it settle
  task automatic run_frames(input logic [31:0] ctrl, input int n);
    int f;
    sq = {};
    st = {};
    wq = {};
    wt = {};
    reg_write(CTRL_OFS, ctrl);
    f = 0;
    while (f < n) begin
      @(posedge clock_i);
      f = 0;
      foreach (sq[i]) f += int'(sq[i].chan[3:1] == 3'h0);
    end
    reg_write(CTRL_OFS, ctrl & 32'hFFFF_FBFF);
    repeat (3) @(posedge low_speed_clock);
    @(posedge clock_i);
  endtask : run_frames

  function automatic int next_frame();
    for (int i = 1; i < sq.size(); i++) if (sq[i].chan[3:1] == 3'h0) return i;
    return 0;
  endfunction : next_frame

  task automatic t_reset();
    logic [31:0] d;
    chk("ready after reset", 1, conv_ready);
    chk("links after reset", 0, link_en);
    reg_read(CTRL_OFS, d);
    chk("ctrl reset", 32'h0000_0007, d);
    reg_read(STATUS_OFS, d);
    chk("status idle", 0, d);
    reg_write(8'h08, 32'h0000_0FFF);
    reg_read(8'h08, d);
    chk("unmapped read", 0, d);
    reg_read(CTRL_OFS, d);
    chk("ctrl after unmapped write", 32'h0000_0007, d);
  endtask : t_reset

  task automatic t_single();
    run_frames(32'h0000_0401, 3);
    chk("frame ticks one state", 3, st[next_frame()] - st[0]);
    chk("even pin single", 0, {sq[0].chan, sq[0].diff});
    run_frames(32'h0000_0C03, 2);
    chk("odd pin single", {CH_I1, 1'b0}, {sq[0].chan, sq[0].diff});
    chk("odd pin address", RAM_BASE, wq[0].addr);
    chk("pair single", {CH_I2, 1'b0}, {sq[2].chan, sq[2].diff});
  endtask : t_single

  task automatic t_local();
    logic [3:0] ec[7] = '{CH_I0, CH_V8, CH_I2, CH_V9, CH_I4, CH_V10, CH_I6};
    int b;
    int n;
    run_frames(32'h0000_05F7, 3);
    b = next_frame();
    chk("states per frame", 7, b);
    chk("frame ticks local", 15, st[b] - st[0]);
    chk("links local", 0, link_en);
    for (int i = 0; i < 7; i++) begin
      chk("channel", ec[i], sq[i].chan);
      chk("differential", ec[i] < CH_V8, sq[i].diff);
      chk("preamp", i == 0, sq[i].preamp);
    end
    n = 0;
    foreach (wq[i]) begin
      chk("ram address", {4'h0, wq[i].data[3:0] & 4'hE}, wq[i].addr);
      chk("ram data", 18'h1_2345, wq[i].data[21:4]);
      n += int'(wt[i] >= st[0] && wt[i] < st[b]);
    end
    chk("writes per frame", 7, n);
  endtask : t_local

  task automatic t_remote();
    logic [3:0] ec[4] = '{CH_I0, CH_V8, CH_V9, CH_V10};
    int b;
    int n;
    run_frames(32'h0000_0616, 3);
    b = next_frame();
    chk("states remote", 4, b);
    chk("frame ticks remote", 13, st[b] - st[0]);
    chk("links remote", 3'h7, link_en);
    for (int i = 0; i < 4; i++) chk("remote channel", ec[i], sq[i].chan);
    n = 0;
    foreach (wq[i]) begin
      if (wq[i].data[21:4] == 18'h2_6789 && wt[i] >= st[0] && wt[i] < st[b]) begin
        n++;
        chk("remote address", 8'(2 * (wq[i].data[1:0] + 1)), wq[i].addr);
        chk("remote tick", 1, int'((wt[i] - st[0]) inside {[7:12]}));
      end
    end
    chk("remote writes", 3, n);
  endtask : t_remote

  task automatic t_buffer();
    logic [31:0] d;
    rdy <= 1'b0;
    sq = {};
    wq = {};
    reg_write(CTRL_OFS, 32'h0000_05F7);
    while (sq.size() < 3) @(posedge clock_i);
    reg_read(STATUS_OFS, d);
    chk("status running", 1, d[7]);
    chk("status state", 3, d[3:0]);
    repeat (60) @(posedge clock_i);
    chk("ready when full", 0, conv_ready);
    chk("valid when full", 1, ram_wr_valid);
    rdy <= 1'b1;
    repeat (5) @(posedge clock_i);
    chk("drained count", 2, wq.size());
    chk("first drained", CH_I0, wq[0].addr);
    chk("second drained", CH_V8, wq[1].addr);
    reg_write(CTRL_OFS, 32'h0000_01F7);
  endtask : t_buffer

  initial begin
    repeat (16) @(posedge clock_i);
    rst_i <= 1'b0;
    t_reset();
    t_single();
    t_local();
    t_remote();
    t_buffer();
    tally_and_finish();
  end
endmodule : tb
